// ==== dec_timer.sv ====
// Down counter that flags a 0 to 1 change of its top bit
`timescale 1ns/1ps
module dec_timer
   import exc_pkg::*;
#(
   parameter int unsigned W = DW
)
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic load_i,
   input wire logic [W-1:0] load_val_i,
   output logic [W-1:0] value_o,
   output logic fire_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic fire;
   } dec_s;

   dec_s q;
   dec_s d;

   always_comb
   begin
      d = q;
      d.cnt = load_i ? load_val_i : q.cnt - W'(1);
      // Keeps counting in nap, so it can wake the core
      d.fire = d.cnt[W-1] & ~q.cnt[W-1];
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         q <= '{cnt: DEC_RST[W-1:0], fire: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   assign value_o = q.cnt;
   assign fire_o = q.fire;
endmodule : dec_timer

// ==== exc_pick.sv ====
// Fixed-priority selection of one exception cause
`timescale 1ns/1ps
module exc_pick
   import exc_pkg::*;
#(
   parameter int unsigned N = NCAUSE
)
(
   input wire logic [N-1:0] req_i,
   output logic [N-1:0] grant_o,
   output logic any_o,
   output logic [VW-1:0] vec_o
);
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_pri
         if (i == 0)
         begin : g_top
            assign grant_o[i] = req_i[i];
         end
         else
         begin : g_rest
            assign grant_o[i] = req_i[i] & ~|req_i[i-1:0];
         end
      end
   endgenerate

   assign any_o = |req_i;

   always_comb
   begin
      vec_o = '0;
      for (int k = 0; k < N; k++)
      begin
         if (grant_o[k])
         begin
            vec_o = vec_o | cause_vec(k);
         end
      end
   end
endmodule : exc_pick

// ==== exc_pkg.sv ====
// Shared constants and types of the exception and nap unit
package exc_pkg;
   localparam int unsigned AW = 3;
   localparam int unsigned DW = 32;
   localparam int unsigned BEW = DW / 8;
   localparam int unsigned VW = 20;
   localparam int unsigned CW = 8;
   localparam int unsigned NPMC = 4;
   localparam int unsigned NPEND = 2;
   // Register word addresses
   localparam logic [AW-1:0] A_CTRL = 3'h0;
   localparam logic [AW-1:0] A_DEC = 3'h1;
   localparam logic [AW-1:0] A_INSN_BREAKPOINT_REG = 3'h2;
   localparam logic [AW-1:0] A_PMEN = 3'h3;
   localparam logic [AW-1:0] A_STAT = 3'h4;
   localparam logic [AW-1:0] A_SAVED = 3'h5;
   localparam logic [AW-1:0] A_SIA = 3'h6;
   // Control register bits
   localparam int B_EE = 0;
   localparam int B_FP = 1;
   localparam int B_SE = 2;
   localparam int B_BE = 3;
   localparam int B_PR = 4;
   localparam int B_FE0 = 5;
   localparam int B_FE1 = 6;
   localparam int B_POW = 7;
   localparam logic [CW-1:0] CTRL_RST = 8'h00;
   localparam logic [DW-1:0] DEC_RST = 32'h7FFF_FFFF;
   // Breakpoint: address bits 0..29 and enable bit 30, big-endian numbering
   localparam int INSN_BREAKPOINT_REG_EN = 1;
   localparam int INSN_BREAKPOINT_REG_LO = 2;
   // Pending sticky bits
   localparam int P_DEC = 0;
   localparam int P_PERF = 1;
   // Status layout
   localparam int T_HALT = 0;
   localparam int T_PEND_LO = 4;
   localparam int T_ST_LO = 8;
   // Saved state layout and program subcause bits
   localparam int S_SUB_LO = 8;
   localparam int S_VEC_LO = 12;
   localparam int Q_FPX = 0;
   localparam int Q_ILL = 1;
   localparam int Q_PRIV = 2;
   localparam int Q_TRAP = 3;
   // Cause indices, lowest index wins
   localparam int C_INSN_BREAKPOINT_REG = 0;
   localparam int C_FPUN = 1;
   localparam int C_PROG = 2;
   localparam int C_ALIGN = 3;
   localparam int C_SC = 4;
   localparam int C_TRACE = 5;
   localparam int C_EXT = 6;
   localparam int C_SMI = 7;
   localparam int C_DEC = 8;
   localparam int C_PERF = 9;
   localparam int unsigned NCAUSE = 10;
   typedef enum logic [3:0] {OP_NONE, OP_FPLS, OP_MULTI, OP_RESV, OP_EXTCTL, OP_ZBLK, OP_FP,
      OP_SC, OP_BR, OP_RFI, OP_PRIV, OP_SPR, OP_TRAP, OP_ILL, OP_UNIMPL} op_e;
   typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_NDRAIN, ST_NAP} nap_st_e;

   function automatic logic [VW-1:0] cause_vec(input int c);
      case (c)
         C_INSN_BREAKPOINT_REG: cause_vec = 20'h01300;
         C_FPUN: cause_vec = 20'h00800;
         C_PROG: cause_vec = 20'h00700;
         C_ALIGN: cause_vec = 20'h00600;
         C_SC: cause_vec = 20'h00C00;
         C_TRACE: cause_vec = 20'h00D00;
         C_EXT: cause_vec = 20'h00500;
         C_SMI: cause_vec = 20'h01400;
         C_DEC: cause_vec = 20'h00900;
         C_PERF: cause_vec = 20'h00F00;
         default: cause_vec = 20'h00000;
      endcase
   endfunction : cause_vec
endpackage : exc_pkg

// ==== exc_unit.sv ====
// Exception recognition, vectoring and nap control with Avalon-MM registers
`timescale 1ns/1ps
module exc_unit
   import exc_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [DW-1:0] avs_writedata_i,
   input wire logic [BEW-1:0] avs_byteenable_i,
   output logic [DW-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic ext_irq_i,
   input wire logic sys_mgmt_irq_in_i,
   input wire logic run_i,
   output logic nap_out_a_o,
   input wire logic cmp_valid_i,
   input wire op_e cmp_op_i,
   input wire logic [DW-1:0] cmp_pc_i,
   input wire logic [1:0] cmp_ea_lo_i,
   input wire logic cmp_page_wt_ci_i,
   input wire logic dcache_off_i,
   input wire logic cmp_fex_i,
   input wire logic cmp_spr_top_i,
   input wire logic cmp_trap_true_i,
   input wire logic cmp_mispred_i,
   input wire logic inflight_i,
   input wire logic bus_busy_i,
   input wire logic [NPMC-1:0] perf_neg_i,
   output logic dispatch_hold_o,
   output logic flush_o,
   output logic take_o,
   output logic [VW-1:0] vector_o,
   output logic clk_stop_o,
   output logic snoop_en_o
);
   typedef struct packed {
      nap_st_e st;
      logic [CW-1:0] ctrl;
      logic [DW-1:0] insn_breakpoint_reg;
      logic [NPMC-1:0] pmen;
      logic [NPMC-1:0] neg_prev;
      logic [NPEND-1:0] pend;
      logic [DW-1:0] saved;
      logic [DW-1:0] sampled_insn_addr;
      logic [VW-1:0] vec;
      logic [DW-1:0] rdata;
      logic ack;
      logic take;
      logic flush;
      logic halt;
   } unit_s;

   unit_s q;
   unit_s d;

   logic [DW-1:0] dec_val;
   logic dec_fire;
   logic dec_load;
   logic [DW-1:0] dec_wval;
   logic [NCAUSE-1:0] req;
   logic [NCAUSE-1:0] grant;
   logic pick_any;
   logic [VW-1:0] pick_vec;
   logic bus_req;
   logic v;
   logic ee;
   logic word_op;
   logic fpx;
   logic ill;
   logic priv;
   logic trap;
   logic async_ok;
   logic async_any;
   logic wake;
   logic [3:0] sub;
   logic [NPMC-1:0] neg_rise;
   logic [DW-1:0] merged;

   function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] old_v, input logic [DW-1:0] new_v,
                                               input logic [BEW-1:0] be);
      logic [DW-1:0] r;
      r = old_v;
      for (int b = 0; b < BEW; b++)
      begin
         if (be[b])
         begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   dec_timer #(
      .W(DW)
   ) u_dec (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .load_i(dec_load),
      .load_val_i(dec_wval),
      .value_o(dec_val),
      .fire_o(dec_fire)
   );

   exc_pick #(
      .N(NCAUSE)
   ) u_pick (
      .req_i(req),
      .grant_o(grant),
      .any_o(pick_any),
      .vec_o(pick_vec)
   );

   assign bus_req = avs_read_i | avs_write_i;
   // One wait state, so every access completes on its second edge
   assign avs_waitrequest_o = bus_req & ~q.ack;
   assign avs_readdata_o = q.rdata;

   // Cause detection on the instruction now completing
   always_comb
   begin
      ee = q.ctrl[B_EE];
      v = cmp_valid_i && (q.st != ST_NAP);
      word_op = (cmp_op_i == OP_FPLS) || (cmp_op_i == OP_MULTI) || (cmp_op_i == OP_RESV)
                || (cmp_op_i == OP_EXTCTL);
      // Mode bits both zero: result is a default value, no trap
      fpx = (cmp_op_i == OP_FP) && cmp_fex_i && (q.ctrl[B_FE0] || q.ctrl[B_FE1]);
      ill = (cmp_op_i == OP_ILL) || (cmp_op_i == OP_UNIMPL);
      priv = q.ctrl[B_PR] && ((cmp_op_i == OP_PRIV) || ((cmp_op_i == OP_SPR) && cmp_spr_top_i));
      trap = (cmp_op_i == OP_TRAP) && cmp_trap_true_i;
      sub = '0;
      sub[Q_FPX] = fpx;
      sub[Q_ILL] = ill;
      sub[Q_PRIV] = priv;
      sub[Q_TRAP] = trap;
      neg_rise = perf_neg_i & ~q.neg_prev & q.pmen;
      async_any = ext_irq_i || sys_mgmt_irq_in_i || (|q.pend);
      // Asynchronous only once nothing dispatched or completing remains
      async_ok = ee && !inflight_i && !cmp_valid_i && (q.st != ST_NAP);
      wake = ext_irq_i || sys_mgmt_irq_in_i || dec_fire || (|q.pend) || (|neg_rise);
      req = '0;
      req[C_INSN_BREAKPOINT_REG] = v && q.insn_breakpoint_reg[INSN_BREAKPOINT_REG_EN]
                    && (cmp_pc_i[DW-1:INSN_BREAKPOINT_REG_LO] == q.insn_breakpoint_reg[DW-1:INSN_BREAKPOINT_REG_LO]);
      req[C_FPUN] = v && !q.ctrl[B_FP]
                    && ((cmp_op_i == OP_FPLS) || (cmp_op_i == OP_FP));
      req[C_PROG] = v && (fpx || ill || priv || trap);
      req[C_ALIGN] = v && (((|cmp_ea_lo_i) && word_op)
                     || ((cmp_op_i == OP_ZBLK) && (cmp_page_wt_ci_i || dcache_off_i)));
      req[C_SC] = v && (cmp_op_i == OP_SC);
      req[C_TRACE] = v && ((q.ctrl[B_SE] && (cmp_op_i != OP_RFI))
                     || (q.ctrl[B_BE] && (cmp_op_i == OP_BR)));
      req[C_EXT] = async_ok && ext_irq_i;
      req[C_SMI] = async_ok && sys_mgmt_irq_in_i;
      req[C_DEC] = async_ok && q.pend[P_DEC];
      req[C_PERF] = async_ok && q.pend[P_PERF];
   end

   always_comb
   begin
      d = q;
      d.ack = 1'b0;
      d.take = 1'b0;
      d.flush = 1'b0;
      d.neg_prev = perf_neg_i;
      dec_load = 1'b0;
      dec_wval = dec_val;
      merged = '0;

      // Register access
      if (bus_req && !q.ack)
      begin
         d.ack = 1'b1;
         if (avs_write_i)
         begin
            case (avs_address_i)
               A_CTRL:
               begin
                  merged = be_merge({{(DW-CW){1'b0}}, q.ctrl}, avs_writedata_i, avs_byteenable_i);
                  d.ctrl = merged[CW-1:0];
               end
               A_DEC:
               begin
                  dec_load = 1'b1;
                  dec_wval = be_merge(dec_val, avs_writedata_i, avs_byteenable_i);
               end
               A_INSN_BREAKPOINT_REG:
               begin
                  d.insn_breakpoint_reg = be_merge(q.insn_breakpoint_reg, avs_writedata_i, avs_byteenable_i);
               end
               A_PMEN:
               begin
                  merged = be_merge({{(DW-NPMC){1'b0}}, q.pmen}, avs_writedata_i, avs_byteenable_i);
                  d.pmen = merged[NPMC-1:0];
               end
               default:
               begin
                  d.ack = 1'b1;
               end
            endcase
         end
         else
         begin
            d.rdata = '0;
            case (avs_address_i)
               A_CTRL: d.rdata[CW-1:0] = q.ctrl;
               A_DEC: d.rdata = dec_val;
               A_INSN_BREAKPOINT_REG: d.rdata = q.insn_breakpoint_reg;
               A_PMEN: d.rdata[NPMC-1:0] = q.pmen;
               A_STAT:
               begin
                  d.rdata[T_HALT] = q.halt;
                  d.rdata[T_PEND_LO +: NPEND] = q.pend;
                  d.rdata[T_ST_LO +: 2] = q.st;
               end
               A_SAVED: d.rdata = q.saved;
               A_SIA: d.rdata = q.sampled_insn_addr;
               default: d.rdata = '0;
            endcase
         end
      end

      // Dispatch and nap sequencing
      case (q.st)
         ST_RUN:
         begin
            if (q.ctrl[B_POW])
            begin
               d.st = ST_NDRAIN;
            end
            else if (ee && async_any)
            begin
               d.st = ST_DRAIN;
            end
         end
         ST_DRAIN:
         begin
            // Input dropped before being taken: resume, nothing is latched
            if (!ee || !async_any)
            begin
               d.st = ST_RUN;
            end
         end
         ST_NDRAIN:
         begin
            if (!inflight_i && !bus_busy_i)
            begin
               d.st = ST_NAP;
            end
         end
         ST_NAP:
         begin
            if (wake)
            begin
               d.ctrl[B_POW] = 1'b0;
               d.st = ST_DRAIN;
            end
         end
         default:
         begin
            d.st = ST_RUN;
         end
      endcase

      // Units report faults with finish; only completion acts on them
      if (pick_any)
      begin
         d.take = 1'b1;
         d.flush = 1'b1;
         d.vec = pick_vec;
         d.saved = {pick_vec[VW-1:0], sub, q.ctrl};
         d.ctrl[B_EE] = 1'b0;
         d.ctrl[B_SE] = 1'b0;
         d.ctrl[B_BE] = 1'b0;
         d.ctrl[B_PR] = 1'b0;
         d.ctrl[B_POW] = 1'b0;
         d.st = ST_RUN;
         if (grant[C_DEC])
         begin
            d.pend[P_DEC] = 1'b0;
         end
         if (grant[C_PERF])
         begin
            d.pend[P_PERF] = 1'b0;
         end
      end
      else if (v && cmp_mispred_i)
      begin
         d.flush = 1'b1;
      end

      // Hardware sets come last so a same-cycle clear loses
      if (dec_fire)
      begin
         d.pend[P_DEC] = 1'b1;
      end
      if (|neg_rise)
      begin
         d.pend[P_PERF] = 1'b1;
         d.sampled_insn_addr = cmp_pc_i;
      end

      d.halt = (d.st == ST_NAP) && !run_i;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         q <= '{st: ST_RUN, ctrl: CTRL_RST, default: '0};
      end
      else
      begin
         q <= d;
      end
   end

   assign dispatch_hold_o = (q.st != ST_RUN);
   assign flush_o = q.flush;
   assign take_o = q.take;
   assign vector_o = q.vec;
   assign nap_out_a_o = q.halt;
   assign clk_stop_o = (q.st == ST_NAP);
   // Snoop only while awake or while the system holds run
   assign snoop_en_o = (q.st != ST_NAP) || run_i;
endmodule : exc_unit

// ==== exc_unit_checker.sv ====
// Concurrent checks on the ports of the exception and nap unit
`timescale 1ns/1ps
module exc_unit_checker
   import exc_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic sys_mgmt_irq_in_i,
   input wire logic run_i,
   input wire logic nap_out_a_o,
   input wire logic cmp_valid_i,
   input wire op_e cmp_op_i,
   input wire logic cmp_trap_true_i,
   input wire logic cmp_mispred_i,
   input wire logic inflight_i,
   input wire logic bus_busy_i,
   input wire logic dispatch_hold_o,
   input wire logic flush_o,
   input wire logic take_o,
   input wire logic [VW-1:0] vector_o,
   input wire logic clk_stop_o,
   input wire logic snoop_en_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   vec_legal_a: assert property (take_o |-> !(vector_o inside {[20'h00A00:20'h00BFF], [20'h00E00:20'h00EFF]}))
      else $error("take to an unimplemented vector");
   sc_take_a: assert property (cmp_valid_i && !clk_stop_o && cmp_op_i == OP_SC |=> take_o && flush_o)
      else $error("system call not taken");
   trap_take_a: assert property (cmp_valid_i && !clk_stop_o && cmp_op_i == OP_TRAP && cmp_trap_true_i |=> take_o)
      else $error("true trap not taken");
   mispred_flush_a: assert property (cmp_valid_i && !clk_stop_o && cmp_mispred_i |=> flush_o)
      else $error("mispredict without flush");
   ext_drain_a: assert property (take_o && vector_o == 20'h00500 |-> $past(!inflight_i))
      else $error("external taken with work in flight");
   smi_level_a: assert property (take_o && vector_o == 20'h01400 |-> $past(sys_mgmt_irq_in_i))
      else $error("management interrupt without input");
   nap_quiet_a: assert property ($rose(clk_stop_o) |-> $past(!inflight_i && !bus_busy_i))
      else $error("clocks stopped before drain");
   nap_hold_a: assert property ($rose(clk_stop_o) |-> $past(dispatch_hold_o))
      else $error("dispatch open while napping");
   run_halt_a: assert property ($past(run_i) |-> !nap_out_a_o)
      else $error("nap_out_a while run asserted");
   run_snoop_a: assert property (run_i |-> snoop_en_o)
      else $error("no snoop while run asserted");
   cover property (take_o && vector_o == 20'h00500);
   cover property (nap_out_a_o);
   cover property (flush_o && !take_o);
endmodule : exc_unit_checker

// ==== exc_unit_tb.sv ====
// Self-checking bench of the exception and nap unit
`timescale 1ns/1ps
module exc_unit_tb;
   import exc_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [AW-1:0] avs_address_i = '0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [DW-1:0] avs_writedata_i = '0;
   logic [BEW-1:0] avs_byteenable_i = 4'hF;
   logic [DW-1:0] avs_readdata_o;
   logic avs_waitrequest_o, ext_irq_i, sys_mgmt_irq_in_i, run_i, nap_out_a_o;
   logic cmp_valid_i = 1'b0;
   op_e cmp_op_i = OP_NONE;
   logic [DW-1:0] cmp_pc_i = 32'h0000_1000;
   logic [1:0] cmp_ea_lo_i = 2'h0;
   logic cmp_page_wt_ci_i = 1'b0, dcache_off_i = 1'b0, cmp_fex_i = 1'b0, cmp_spr_top_i = 1'b0;
   logic cmp_trap_true_i = 1'b0, cmp_mispred_i = 1'b0, inflight_i = 1'b0, bus_busy_i = 1'b0;
   logic [NPMC-1:0] perf_neg_i = 4'h0;
   logic dispatch_hold_o, flush_o, take_o, clk_stop_o, snoop_en_o;
   logic [VW-1:0] vector_o;
   logic ext_req = 1'b0, smi_req = 1'b0, run_req = 1'b0;
   logic [DW-1:0] q;
   int fails = 0;
   int check_count = 0;
   exc_unit i_exc_unit (.clk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
      .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .ext_irq_i, .sys_mgmt_irq_in_i, .run_i,
      .nap_out_a_o, .cmp_valid_i, .cmp_op_i, .cmp_pc_i, .cmp_ea_lo_i, .cmp_page_wt_ci_i, .dcache_off_i,
      .cmp_fex_i, .cmp_spr_top_i, .cmp_trap_true_i, .cmp_mispred_i, .inflight_i, .bus_busy_i, .perf_neg_i,
      .dispatch_hold_o, .flush_o, .take_o, .vector_o, .clk_stop_o, .snoop_en_o);
   irq_partner i_irq_partner (.clk_i, .arst_n_i, .ext_req_i(ext_req), .smi_req_i(smi_req), .run_req_i(run_req),
      .take_i(take_o), .vector_i(vector_o), .ext_irq_o(ext_irq_i), .smi_o(sys_mgmt_irq_in_i), .run_o(run_i));
   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One Avalon access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      avs_writedata_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (avs_waitrequest_o !== 1'b0 && n < 20);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (n >= 20)
      begin
         fails++;
         complete_run();
      end
   endtask : bus
   task automatic wait_take(input logic [VW-1:0] v);
      int n;
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (take_o !== 1'b1 && n < 60);
      chk("vector", vector_o, v);
      if (take_o !== 1'b1)
      begin
         fails++;
         complete_run();
      end
   endtask : wait_take
   // Flag bits: page, cache off, fp summary, spr top, trap true, mispredict
   task automatic row(input logic [7:0] c, input op_e op, input logic [1:0] ea, input logic [5:0] f,
      input logic [VW-1:0] v);
      bus(1'b1, A_CTRL, {24'h0, c});
      @(posedge clk_i);
      cmp_valid_i <= 1'b1;
      cmp_op_i <= op;
      cmp_ea_lo_i <= ea;
      {cmp_page_wt_ci_i, dcache_off_i, cmp_fex_i, cmp_spr_top_i, cmp_trap_true_i, cmp_mispred_i} <= f;
      @(posedge clk_i);
      cmp_valid_i <= 1'b0;
      @(negedge clk_i);
      chk("take", take_o, v != 20'h0);
      chk("flush", flush_o, v != 20'h0 || f[0]);
      if (v != 20'h0)
         chk("vector", vector_o, v);
   endtask : row
   initial
   begin
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      bus(1'b0, A_CTRL, 32'h0);
      chk("ctrl", q, 32'h0);
      bus(1'b1, 3'h7, 32'hFFFF_FFFF);
      bus(1'b0, 3'h7, 32'h0);
      chk("unmapped", q, 32'h0);
      $display("test registers done");
      row(8'h02, OP_FPLS, 2'h1, 6'h00, 20'h00600);
      row(8'h02, OP_MULTI, 2'h2, 6'h00, 20'h00600);
      row(8'h02, OP_RESV, 2'h3, 6'h00, 20'h00600);
      row(8'h02, OP_EXTCTL, 2'h1, 6'h00, 20'h00600);
      row(8'h02, OP_FPLS, 2'h0, 6'h00, 20'h0);
      row(8'h02, OP_ZBLK, 2'h0, 6'h20, 20'h00600);
      row(8'h02, OP_ZBLK, 2'h0, 6'h10, 20'h00600);
      row(8'h02, OP_ZBLK, 2'h0, 6'h00, 20'h0);
      row(8'h02, OP_FP, 2'h0, 6'h08, 20'h0);
      row(8'h22, OP_FP, 2'h0, 6'h08, 20'h00700);
      row(8'h42, OP_FP, 2'h0, 6'h08, 20'h00700);
      row(8'h20, OP_FP, 2'h0, 6'h08, 20'h00800);
      row(8'h00, OP_FPLS, 2'h0, 6'h00, 20'h00800);
      row(8'h02, OP_ILL, 2'h0, 6'h00, 20'h00700);
      row(8'h02, OP_UNIMPL, 2'h0, 6'h00, 20'h00700);
      row(8'h12, OP_PRIV, 2'h0, 6'h00, 20'h00700);
      row(8'h02, OP_PRIV, 2'h0, 6'h00, 20'h0);
      row(8'h12, OP_SPR, 2'h0, 6'h04, 20'h00700);
      row(8'h02, OP_TRAP, 2'h0, 6'h02, 20'h00700);
      bus(1'b0, A_SAVED, 32'h0);
      chk("saved", q[31:8], 24'h007008);
      row(8'h02, OP_TRAP, 2'h0, 6'h00, 20'h0);
      row(8'h02, OP_SC, 2'h0, 6'h00, 20'h00C00);
      row(8'h06, OP_NONE, 2'h0, 6'h00, 20'h00D00);
      row(8'h06, OP_RFI, 2'h0, 6'h00, 20'h0);
      row(8'h0A, OP_BR, 2'h0, 6'h00, 20'h00D00);
      row(8'h02, OP_BR, 2'h0, 6'h01, 20'h0);
      row(8'h06, OP_SC, 2'h0, 6'h00, 20'h00C00);
      bus(1'b1, A_INSN_BREAKPOINT_REG, 32'h0000_1002);
      row(8'h02, OP_SC, 2'h0, 6'h00, 20'h01300);
      bus(1'b1, A_INSN_BREAKPOINT_REG, 32'h0000_1000);
      row(8'h02, OP_NONE, 2'h0, 6'h00, 20'h0);
      $display("test synchronous done");
      bus(1'b1, A_CTRL, 32'h03);
      inflight_i <= 1'b1;
      ext_req <= 1'b1;
      @(posedge clk_i);
      ext_req <= 1'b0;
      repeat (6) @(negedge clk_i);
      chk("hold", dispatch_hold_o, 1'b1);
      chk("vector", vector_o, 20'h01300);
      @(posedge clk_i);
      inflight_i <= 1'b0;
      wait_take(20'h00500);
      repeat (2) @(negedge clk_i);
      chk("ext", ext_irq_i, 1'b0);
      chk("hold", dispatch_hold_o, 1'b0);
      bus(1'b1, A_CTRL, 32'h0);
      smi_req <= 1'b1;
      @(posedge clk_i);
      smi_req <= 1'b0;
      repeat (8) @(negedge clk_i);
      chk("vector", vector_o, 20'h00500);
      bus(1'b1, A_CTRL, 32'h01);
      wait_take(20'h01400);
      bus(1'b1, A_CTRL, 32'h01);
      bus(1'b1, A_DEC, 32'h3);
      wait_take(20'h00900);
      bus(1'b1, A_CTRL, 32'h0);
      bus(1'b1, A_PMEN, 32'hB);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk_i);
         perf_neg_i <= (i == 0) ? 4'h4 : 4'h8;
         repeat (3) @(posedge clk_i);
         perf_neg_i <= 4'h0;
         bus(1'b0, A_STAT, 32'h0);
         chk("pending", q[5], i);
      end
      chk("vector", vector_o, 20'h00900);
      bus(1'b1, A_CTRL, 32'h01);
      wait_take(20'h00F00);
      $display("test asynchronous done");
      @(posedge clk_i);
      inflight_i <= 1'b1;
      bus_busy_i <= 1'b1;
      bus(1'b1, A_CTRL, 32'h80);
      repeat (5) @(posedge clk_i);
      inflight_i <= 1'b0;
      repeat (5) @(negedge clk_i);
      chk("clkstop", clk_stop_o, 1'b0);
      chk("hold", dispatch_hold_o, 1'b1);
      @(posedge clk_i);
      bus_busy_i <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk("nap_out_a", nap_out_a_o, 1'b1);
      chk("clkstop", clk_stop_o, 1'b1);
      chk("snoop", snoop_en_o, 1'b0);
      @(posedge clk_i);
      run_req <= 1'b1;
      repeat (3) @(negedge clk_i);
      chk("nap_out_a", nap_out_a_o, 1'b0);
      chk("snoop", snoop_en_o, 1'b1);
      chk("clkstop", clk_stop_o, 1'b1);
      @(posedge clk_i);
      run_req <= 1'b0;
      ext_req <= 1'b1;
      @(posedge clk_i);
      ext_req <= 1'b0;
      repeat (4) @(negedge clk_i);
      chk("clkstop", clk_stop_o, 1'b0);
      bus(1'b0, A_CTRL, 32'h0);
      chk("powersave", q[7], 1'b0);
      bus(1'b1, A_CTRL, 32'h01);
      wait_take(20'h00500);
      $display("test nap done");
      complete_run();
   end
endmodule : exc_unit_tb
bind exc_unit exc_unit_checker i_exc_unit_checker (.clk_i, .arst_n_i, .sys_mgmt_irq_in_i, .run_i, .nap_out_a_o,
   .cmp_valid_i, .cmp_op_i, .cmp_trap_true_i, .cmp_mispred_i, .inflight_i, .bus_busy_i, .dispatch_hold_o,
   .flush_o, .take_o, .vector_o, .clk_stop_o, .snoop_en_o);

// ==== irq_partner.sv ====
// System interrupt and power-management partner model
`timescale 1ns/1ps
module irq_partner
   import exc_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ext_req_i,
   input wire logic smi_req_i,
   input wire logic run_req_i,
   input wire logic take_i,
   input wire logic [VW-1:0] vector_i,
   output logic ext_irq_o,
   output logic smi_o,
   output logic run_o
);
   // Interrupt requests are latched levels, dropped only once the handler has been entered; run_o only registers run_req_i
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ext_irq_o <= 1'b0;
         smi_o <= 1'b0;
         run_o <= 1'b0;
      end
      else
      begin
         ext_irq_o <= (ext_irq_o || ext_req_i) && !(take_i && vector_i == 20'h00500);
         smi_o <= (smi_o || smi_req_i) && !(take_i && vector_i == 20'h01400);
         run_o <= run_req_i;
      end
   end
endmodule : irq_partner
